// *** usb_ep_irq_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef USB_EP_IRQ_MAP_SVH
`define USB_EP_IRQ_MAP_SVH
`define OFS_IN_MASK 12'h810
`define OFS_OUT_MASK 12'h814
`define OFS_SUMMARY 12'h818
`define OFS_SUM_EN 12'h81c
`define OFS_DISCHARGE 12'h828
`define OFS_PULSE 12'h82c
`define OFS_SRP_CTRL 12'h830
`define BIT_XFER_DONE 0
`define BIT_EP_DIS 1
`define BIT_CTRL_TMO 3
`define BIT_SETUP_DONE 3
`define BIT_FIFO_ERR 4
`define BIT_NAK_EFF 6
`define BIT_B2B_SETUP 6
`define IN_MASK_BITS 32'h0000005b
`define OUT_MASK_BITS 32'h0000005b
`define IN_SUM_LSB 0
`define OUT_SUM_LSB 16
`define RST_DISCHARGE 16'h17d7
`define RST_PULSE 12'h5b8
`define PRESCALE_DIV 1024
`endif

// *** usb_ep_irq_pkg.sv ***
// types shared by the endpoint interrupt and vbus timer block
`default_nettype none
package usb_ep_irq_pkg;
    typedef enum logic [1:0] {SRP_IDLE, SRP_PULSE, SRP_DISCH} srp_state_e;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage
`default_nettype wire

// *** vbus_prescaler.sv ***
// divide-by-1024 tick generator for the vbus timers
`default_nettype none
module vbus_prescaler #(
    parameter int DIV = 1024
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic run,
    output logic tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_q;
    initial begin
        if (DIV < 2) begin
            $error("DIV must be at least 2");
        end
    end
    // restarted when idle so each phase unit is a full 1024 clocks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clkEn) begin
            if (!run || cnt_q == W'(DIV - 1)) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
    assign tick = run && (cnt_q == W'(DIV - 1));
endmodule
`default_nettype wire

// *** usb_ep_irq_vbus.sv ***
// endpoint interrupt aggregation and session request vbus timers
// Operation
// - IN endpoint flag reaches its summary bit only when IN mask bit set
// - IN mask bit 6 gates the NAK-effective flag
// - IN mask bit 4 gates the transmit FIFO underrun flag
// - IN mask bit 3 gates the control IN timeout flag
// - in both masks bit 1 gates endpoint-disabled, bit 0 transfer-done
// - OUT mask bit 6 gates back-to-back SETUP, control OUT only
// - OUT mask bit 4 gates the receive FIFO overrun flag
// - OUT mask bit 3 gates SETUP-phase-done, control OUT only
// - a triggered endpoint interrupt shows in the read-only summary
// - summary and enable: IN 0-3 on bits 3:0, OUT 0-3 on 19:16
// - only enabled endpoints drive the global IN or OUT flag
// - a vbus pulse phase is always followed by a discharge phase
// - discharge lasts 1024 times the 16-bit field; resets to 0x17d7
// - pulse lasts 1024 times the 12-bit field; resets to 0x5b8
`include "usb_ep_irq_map.svh"
`default_nettype none
module usb_ep_irq_vbus
    import usb_ep_irq_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int PRESCALE = `PRESCALE_DIV
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata_q,
    // per-endpoint flag registers, one 8-bit group per endpoint
    input wire logic [NUM_EP*8-1:0] inEpFlags,
    input wire logic [NUM_EP*8-1:0] outEpFlags,
    // global flags toward the core interrupt register
    output logic globalInEpFlag_q,
    output logic globalOutEpFlag_q,
    // session request vbus drive
    output logic vbusPulse_q,
    output logic vbusDischarge_q,
    output logic srpBusy_q
);
    initial begin
        if (NUM_EP < 1 || NUM_EP > 16) begin
            $error("NUM_EP must be 1 to 16");
        end
    end

    reg_req_s req;
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    logic [31:0] inMask_q;
    logic [31:0] outMask_q;
    logic [NUM_EP-1:0] inSumEn_q;
    logic [NUM_EP-1:0] outSumEn_q;
    logic [15:0] dischTime_q;
    logic [11:0] pulseTime_q;
    logic [NUM_EP-1:0] inSum_q;
    logic [NUM_EP-1:0] outSum_q;
    logic [NUM_EP-1:0] inSumD;
    logic [NUM_EP-1:0] outSumD;
    srp_state_e state_q;
    logic [15:0] count_q;
    logic tick;
    logic srpStart;

    function automatic logic hit(input reg_req_s r, input logic [11:0] ofs);
        hit = (r.addr == ofs);
    endfunction

    // masks: only the defined enable bits are stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inMask_q <= '0;
            outMask_q <= '0;
        end else if (clkEn && req.wr) begin
            if (hit(req, `OFS_IN_MASK)) begin
                inMask_q <= req.wdata & `IN_MASK_BITS;
            end
            if (hit(req, `OFS_OUT_MASK)) begin
                outMask_q <= req.wdata & `OUT_MASK_BITS;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inSumEn_q <= '0;
            outSumEn_q <= '0;
        end else if (clkEn && req.wr && hit(req, `OFS_SUM_EN)) begin
            inSumEn_q <= req.wdata[`IN_SUM_LSB +: NUM_EP];
            outSumEn_q <= req.wdata[`OUT_SUM_LSB +: NUM_EP];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dischTime_q <= `RST_DISCHARGE;
            pulseTime_q <= `RST_PULSE;
        end else if (clkEn && req.wr) begin
            if (hit(req, `OFS_DISCHARGE)) begin
                dischTime_q <= req.wdata[15:0];
            end
            if (hit(req, `OFS_PULSE)) begin
                pulseTime_q <= req.wdata[11:0];
            end
        end
    end

    assign srpStart = clkEn && req.wr && hit(req, `OFS_SRP_CTRL)
        && req.wdata[0];

    // per-endpoint summary: masked OR over that endpoint's flags
    for (genvar e = 0; e < NUM_EP; e++) begin : gSum
        logic [7:0] inF;
        logic [7:0] outF;
        assign inF = inEpFlags[e*8 +: 8];
        assign outF = outEpFlags[e*8 +: 8];
        assign inSumD[e] = |(inF & inMask_q[7:0]);
        if (e == 0) begin : gCtrl
            assign outSumD[e] = |(outF & outMask_q[7:0]);
        end else begin : gData
            // setup-only flags have no meaning beyond the control endpoint
            assign outSumD[e] = |(outF & outMask_q[7:0]
                & ~(8'h01 << `BIT_B2B_SETUP)
                & ~(8'h01 << `BIT_SETUP_DONE));
        end
    end

    // summary follows the flags; clearing the source flag clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inSum_q <= '0;
            outSum_q <= '0;
        end else if (clkEn) begin
            inSum_q <= inSumD;
            outSum_q <= outSumD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            globalInEpFlag_q <= 1'b0;
            globalOutEpFlag_q <= 1'b0;
        end else if (clkEn) begin
            globalInEpFlag_q <= |(inSumD & inSumEn_q);
            globalOutEpFlag_q <= |(outSumD & outSumEn_q);
        end
    end

    // session request sequencer: pulse then discharge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SRP_IDLE;
            count_q <= '0;
        end else if (clkEn) begin
            unique case (state_q)
                SRP_IDLE: begin
                    if (srpStart) begin
                        state_q <= SRP_PULSE;
                        count_q <= {4'h0, pulseTime_q};
                    end
                end
                SRP_PULSE: begin
                    if (count_q == '0) begin
                        state_q <= SRP_DISCH;
                        count_q <= dischTime_q;
                    end else if (tick) begin
                        count_q <= count_q - 1'b1;
                    end
                end
                SRP_DISCH: begin
                    if (count_q == '0) begin
                        state_q <= SRP_IDLE;
                    end else if (tick) begin
                        count_q <= count_q - 1'b1;
                    end
                end
            endcase
        end
    end

    vbus_prescaler #(.DIV(PRESCALE)) uPrescale (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .run(state_q != SRP_IDLE && count_q != '0),
        .tick(tick)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vbusPulse_q <= 1'b0;
            vbusDischarge_q <= 1'b0;
            srpBusy_q <= 1'b0;
        end else if (clkEn) begin
            vbusPulse_q <= (state_q == SRP_PULSE) && count_q != '0;
            vbusDischarge_q <= (state_q == SRP_DISCH) && count_q != '0;
            srpBusy_q <= state_q != SRP_IDLE || srpStart;
        end
    end

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= '0;
        end else if (clkEn) begin
            regRdata_q <= '0;
            if (req.rd) begin
                unique case (req.addr)
                    `OFS_IN_MASK: regRdata_q <= inMask_q;
                    `OFS_OUT_MASK: regRdata_q <= outMask_q;
                    `OFS_SUMMARY: begin
                        regRdata_q[`IN_SUM_LSB +: NUM_EP] <= inSum_q;
                        regRdata_q[`OUT_SUM_LSB +: NUM_EP] <= outSum_q;
                    end
                    `OFS_SUM_EN: begin
                        regRdata_q[`IN_SUM_LSB +: NUM_EP] <= inSumEn_q;
                        regRdata_q[`OUT_SUM_LSB +: NUM_EP] <= outSumEn_q;
                    end
                    `OFS_DISCHARGE: regRdata_q[15:0] <= dischTime_q;
                    `OFS_PULSE: regRdata_q[11:0] <= pulseTime_q;
                    `OFS_SRP_CTRL: regRdata_q[0] <= srpBusy_q;
                    default: regRdata_q <= '0;
                endcase
            end
        end
    end

    sequence sPulseEnd;
        state_q == SRP_PULSE && count_q == '0;
    endsequence

    AST_PULSE_THEN_DISCH: assert property (@(posedge clk_sys)
        disable iff (!rst_n) sPulseEnd ##0 clkEn |=> state_q == SRP_DISCH)
        else $error("pulse not followed by discharge");
    AST_DISCH_LOAD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) sPulseEnd ##0 clkEn |=> count_q == dischTime_q)
        else $error("discharge count not loaded");
    AST_PULSE_LOAD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_IDLE && srpStart
        |=> state_q == SRP_PULSE && count_q == $past(pulseTime_q))
        else $error("pulse count not loaded");
    AST_TICK_STEP: assert property (@(posedge clk_sys)
        disable iff (!rst_n) tick && clkEn && state_q != SRP_IDLE
        |=> count_q == $past(count_q) - 16'h0001)
        else $error("counter did not step on tick");
    AST_IN_SUM: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn |=> inSum_q[0] ==
        $past(|(inEpFlags[7:0] & inMask_q[7:0])))
        else $error("in summary wrong");
    AST_OUT_SUM: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn |=> outSum_q[0] ==
        $past(|(outEpFlags[7:0] & outMask_q[7:0])))
        else $error("out summary wrong");
    AST_GLOBAL_IN: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn && ~|(inSumEn_q) |=> !globalInEpFlag_q)
        else $error("global in flag without enable");
    AST_GLOBAL_OUT: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn && ~|(outSumEn_q) |=> !globalOutEpFlag_q)
        else $error("global out flag without enable");
    AST_RSVD_ZERO: assert property (@(posedge clk_sys)
        disable iff (!rst_n) inMask_q[31:7] == '0 && inMask_q[5] == 1'b0
        && outMask_q[2] == 1'b0)
        else $error("reserved mask bit set");
    AST_OUT_RSVD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) outMask_q[31:7] == '0 && outMask_q[5] == 1'b0
        && inMask_q[2] == 1'b0)
        else $error("reserved out mask bit set");

    sequence sDischEnd;
        state_q == SRP_DISCH && count_q == '0;
    endsequence

    AST_DISCH_TO_IDLE: assert property (@(posedge clk_sys)
        disable iff (!rst_n) sDischEnd ##0 clkEn |=> state_q == SRP_IDLE)
        else $error("discharge did not end");
    AST_PHASE_EXCL: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !(vbusPulse_q && vbusDischarge_q))
        else $error("pulse and discharge overlap");
    AST_PULSE_HOLD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_PULSE && count_q != '0
        && clkEn |=> vbusPulse_q)
        else $error("pulse dropped early");
    AST_DISCH_HOLD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_DISCH && count_q != '0
        && clkEn |=> vbusDischarge_q)
        else $error("discharge dropped early");
    AST_IDLE_QUIET: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_IDLE && clkEn
        |=> !vbusPulse_q && !vbusDischarge_q)
        else $error("vbus driven while idle");
    AST_BUSY_IDLE: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_IDLE && !srpStart && clkEn
        |=> !srpBusy_q)
        else $error("busy while idle");
    AST_NO_TICK_IDLE: assert property (@(posedge clk_sys)
        disable iff (!rst_n) state_q == SRP_IDLE |-> !tick)
        else $error("prescaler ticks while idle");
    AST_FREEZE: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !clkEn
        |=> $stable(state_q) && $stable(count_q))
        else $error("state moved while frozen");
    AST_MASK_HOLD: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !(req.wr && hit(req, `OFS_IN_MASK))
        |=> $stable(inMask_q))
        else $error("in mask changed without write");
    AST_RD_IDLE: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn && !req.rd |=> regRdata_q == '0)
        else $error("read data without strobe");
    AST_RSVD_READ: assert property (@(posedge clk_sys)
        disable iff (!rst_n) clkEn && req.rd && req.addr == `OFS_PULSE
        |=> regRdata_q[31:12] == '0)
        else $error("reserved pulse bits read nonzero");

    // setup-only flags must never light a data endpoint's summary bit
    for (genvar e = 1; e < NUM_EP; e++) begin : gSetupChk
        AST_SETUP_CTRL_ONLY: assert property (@(posedge clk_sys)
            disable iff (!rst_n) clkEn
            && (outEpFlags[e*8 +: 8] & outMask_q[7:0] & ~8'h48) == 8'h00
            |=> !outSum_q[e])
            else $error("setup flag reached data endpoint");
    end
endmodule
`default_nettype wire

// *** usb_host_model.sv ***
// far-side observer that times the session request vbus phases
`default_nettype none
module usb_host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // vbus phases seen on the bus
    input wire logic vbusPulse,
    input wire logic vbusDischarge,
    // measured cycle counts
    output logic [31:0] pulseLen,
    output logic [31:0] dischLen,
    output logic [31:0] gapLen
);
    // pulse and discharge counts accumulate across every session request, gap only in the first; only reset clears them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulseLen <= 32'h0;
            dischLen <= 32'h0;
            gapLen <= 32'h0;
        end else begin
            if (vbusPulse) begin
                pulseLen <= pulseLen + 32'h1;
            end
            if (vbusDischarge) begin
                dischLen <= dischLen + 32'h1;
            end
            // cycles from pulse end up to and including the first discharge cycle
            if (pulseLen != 0 && dischLen == 0 && !vbusPulse) begin
                gapLen <= gapLen + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** usb_device_endpoint_irq_vbus_timing_bench.sv ***
// register-level bench for endpoint interrupt summary and vbus timers
`include "usb_ep_irq_map.svh"
`default_nettype none
module usb_device_endpoint_irq_vbus_timing_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic clkEn = 1'b1;
    logic [31:0] regRdata_q;
    logic [31:0] inEpFlags = 32'h0;
    logic [31:0] outEpFlags = 32'h0;
    logic globalInEpFlag_q, globalOutEpFlag_q;
    logic vbusPulse_q, vbusDischarge_q, srpBusy_q;
    logic [31:0] pulseLen, dischLen, gapLen, rdata;
    int n_fail = 0;
    int check_count = 0;
    int bits[5] = '{0, 1, 3, 4, 6};
    logic [11:0] ofs[6] = '{`OFS_IN_MASK, `OFS_OUT_MASK, `OFS_SUMMARY,
        `OFS_SUM_EN, `OFS_DISCHARGE, `OFS_PULSE};
    logic [31:0] rstVal[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h17d7, 32'h5b8};

    always #50 clk_sys = ~clk_sys;

    usb_ep_irq_vbus #(.NUM_EP(4), .PRESCALE(4)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata_q(regRdata_q),
        .inEpFlags(inEpFlags), .outEpFlags(outEpFlags),
        .globalInEpFlag_q(globalInEpFlag_q),
        .globalOutEpFlag_q(globalOutEpFlag_q),
        .vbusPulse_q(vbusPulse_q), .vbusDischarge_q(vbusDischarge_q),
        .srpBusy_q(srpBusy_q));

    usb_host_model host (
        .clk_sys(clk_sys), .rst_n(rst_n), .vbusPulse(vbusPulse_q),
        .vbusDischarge(vbusDischarge_q), .pulseLen(pulseLen),
        .dischLen(dischLen), .gapLen(gapLen));

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        chk(regRdata_q, exp);
    endtask

    task automatic final_report;
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (ofs[i]) rdchk(ofs[i], rstVal[i]);
        rdchk(12'h800, 32'h0);
        wr(`OFS_IN_MASK, 32'hffffffff);
        rdchk(`OFS_IN_MASK, 32'h5b);
        wr(`OFS_OUT_MASK, 32'hffffffff);
        rdchk(`OFS_OUT_MASK, 32'h5b);
        wr(`OFS_SUM_EN, 32'hffffffff);
        rdchk(`OFS_SUM_EN, 32'h000f000f);
        wr(`OFS_SUMMARY, 32'hffffffff);
        rdchk(`OFS_SUMMARY, 32'h0);
        wr(`OFS_IN_MASK, 32'h0);
        inEpFlags <= 32'hffffffff;
        rdchk(`OFS_SUMMARY, 32'h0);
        // ep2 carries the masked flag, ep0 every other flag
        foreach (bits[i]) begin
            wr(`OFS_IN_MASK, 32'h1 << bits[i]);
            inEpFlags <= (32'h1 << (16 + bits[i])) | (32'hff ^ (32'h1 << bits[i]));
            outEpFlags <= 32'h0;
            rdchk(`OFS_SUMMARY, 32'h4);
            chk({31'h0, globalInEpFlag_q}, 32'h1);
            wr(`OFS_OUT_MASK, 32'h1 << bits[i]);
            outEpFlags <= (32'h101 << bits[i]);
            rdchk(`OFS_SUMMARY, (bits[i] == 3 || bits[i] == 6) ?
                32'h10004 : 32'h30004);
        end
        // a frozen block must ignore a write
        clkEn <= 1'b0;
        wr(`OFS_IN_MASK, 32'h0);
        clkEn <= 1'b1;
        rdchk(`OFS_IN_MASK, 32'h40);
        wr(`OFS_SUM_EN, 32'h000b0000);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, globalInEpFlag_q}, 32'h0);
        chk({31'h0, globalOutEpFlag_q}, 32'h1);
        wr(`OFS_SUM_EN, 32'h00080000);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, globalOutEpFlag_q}, 32'h0);
        // short timer fields keep the run brief with the reduced prescaler
        wr(`OFS_PULSE, 32'hfffff003);
        rdchk(`OFS_PULSE, 32'h3);
        wr(`OFS_DISCHARGE, 32'hffff0002);
        rdchk(`OFS_DISCHARGE, 32'h2);
        wr(`OFS_SRP_CTRL, 32'h1);
        rdchk(`OFS_SRP_CTRL, 32'h1);
        for (int n = 0; n < 500 && srpBusy_q; n++) @(posedge clk_sys);
        @(negedge clk_sys);
        if (srpBusy_q) begin
            n_fail++;
        end else begin
            chk({31'h0, pulseLen >= 12 && pulseLen <= 14}, 32'h1);
            chk({31'h0, dischLen >= 8 && dischLen <= 10}, 32'h1);
            chk({31'h0, gapLen <= 2}, 32'h1);
            chk({30'h0, vbusPulse_q, vbusDischarge_q}, 32'h0);
        end
        final_report();
    end
endmodule
`default_nettype wire
